//--- hdl/sow_pkg.sv
package sow_pkg;
    // Clock rate of sys_clk.
    localparam longint unsigned CLK_HZ = 40_000_000;
    localparam int NUM_CH = 6;

    // Times in their own units, as specified.
    localparam longint unsigned OV_HOLD_US = 25;
    localparam longint unsigned RST_HOLD_MS = 200;
    localparam longint unsigned WD_INIT_MS = 102_400;
    localparam longint unsigned WD_NORM_MS = 1_600;
    localparam longint unsigned MR_MIN_US = 1;
    localparam longint unsigned WDO_PULSE_US = 5;

    // Cycle counts; every figure is a whole number of cycles at 40 MHz.
    localparam longint unsigned OV_CYC_L = (OV_HOLD_US * CLK_HZ + 999_999) / 1_000_000;
    localparam longint unsigned RST_CYC_L = (RST_HOLD_MS * CLK_HZ + 999) / 1_000;
    localparam longint unsigned WD_INIT_CYC_L = (WD_INIT_MS * CLK_HZ + 999) / 1_000;
    localparam longint unsigned WD_NORM_CYC_L = (WD_NORM_MS * CLK_HZ + 999) / 1_000;
    localparam longint unsigned MR_CYC_L = (MR_MIN_US * CLK_HZ + 999_999) / 1_000_000;
    localparam longint unsigned PULSE_CYC_L = (WDO_PULSE_US * CLK_HZ + 999_999) / 1_000_000;

    // Counter widths and the short counts at those widths.
    localparam int OV_W = 11;
    localparam int RST_W = 24;
    localparam int WD_W = 32;
    localparam int MR_W = 6;
    localparam int PULSE_W = 8;
    localparam logic [OV_W-1:0] OV_CYC = OV_W'(OV_CYC_L);
    localparam logic [MR_W-1:0] MR_CYC = MR_W'(MR_CYC_L);
    localparam logic [PULSE_W-1:0] PULSE_CYC = PULSE_W'(PULSE_CYC_L);

    // Pin inputs travel together through the synchroniser.
    typedef struct packed {
        logic [NUM_CH-1:0] uv;
        logic [NUM_CH-1:0] ov;
        logic manual_reset_n;
        logic output_freeze_n;
        logic watchdog_kick_in;
    } sow_pins_t;

    localparam sow_pins_t PINS_IDLE = '{uv: '0, ov: '0, manual_reset_n: 1'b1,
                                        output_freeze_n: 1'b1, watchdog_kick_in: 1'b0};

    // Reset values of the outputs.
    localparam logic RESET_OUT_RST = 1'b0;
    localparam logic OV_FLAG_RST = 1'b0;
    localparam logic WDO_RST = 1'b1;

    typedef enum logic [1:0] {
        WD_CLEAR = 2'h0,
        WD_INITIAL = 2'h1,
        WD_NORMAL = 2'h3,
        WD_FAULT = 2'h2
    } sow_wd_state_t;
endpackage

//--- hdl/sow_supervisor.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01 - Reset, overvoltage and watchdog outputs are all active low.
// R02 - After power-up or a fault, reset and overvoltage stay asserted until timeouts end.
// R03 - Overvoltage flag asserts on any overvoltage; releases 25us after all clear.
// R04 - Reset asserts on any undervoltage or on a valid manual reset.
// R05 - Reset holds 200ms after the last cause clears; a new cause restarts it.
// R06 - Watchdog has an initial period of 102.4s and a normal period of 1.6s.
// R07 - Once the reset output is high after power-up, the initial period starts.
// R08 - After the initial phase each falling kick edge restarts a normal period.
// R09 - No kick within a normal period drives the watchdog output low.
// R10 - After a timeout the watchdog output stays low until the kick changes level.
// R11 - Each return of the watchdog output high starts a fresh initial period.
// R12 - With loopback to manual reset, the watchdog output pulses low about 5us.
// R13 - Asserted reset clears the watchdog and holds it cleared while reset is low; in WD_FAULT the clear waits for pulse_cnt to reach PULSE_CYC.
// R14 - A watchdog-caused reset still lasts the full reset timeout.
// R15 - Manual reset counts only when held low at least 1us; shorter pulses ignored.
// R16 - While the freeze input is low, all three outputs hold their state.
// R17 - Freeze has priority over manual reset.
// R18 - The processor kicks more often than once per normal period.
// R19 - Comparator flags are synchronised and all timeouts use clocked counters.
module sow_supervisor #(
    parameter logic [sow_pkg::RST_W-1:0] RST_CYC = sow_pkg::RST_W'(sow_pkg::RST_CYC_L),
    parameter logic [sow_pkg::WD_W-1:0] WD_INIT_CYC = sow_pkg::WD_W'(sow_pkg::WD_INIT_CYC_L),
    parameter logic [sow_pkg::WD_W-1:0] WD_NORM_CYC = sow_pkg::WD_W'(sow_pkg::WD_NORM_CYC_L)
) (
    // Clock, reset and enable.
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Comparator flags and pins from outside the clock domain.
    input wire logic [sow_pkg::NUM_CH-1:0] uv_flags,
    input wire logic [sow_pkg::NUM_CH-1:0] ov_flags,
    input wire logic manual_reset_n,
    input wire logic output_freeze_n,
    input wire logic watchdog_kick_in,
    // Active-low outputs.
    output logic reset_out_n,
    output logic overvoltage_flag_n,
    output logic watchdog_out_n
);
    sow_pkg::sow_pins_t pins_meta;
    sow_pkg::sow_pins_t pins;
    logic kick_d;
    logic [sow_pkg::OV_W-1:0] ov_cnt;
    logic [sow_pkg::RST_W-1:0] rst_cnt;
    logic [sow_pkg::MR_W-1:0] mr_cnt;
    logic [sow_pkg::WD_W-1:0] wd_cnt;
    logic [sow_pkg::PULSE_W-1:0] pulse_cnt;
    sow_pkg::sow_wd_state_t wd_state;
    logic adv;
    logic any_uv;
    logic any_ov;
    logic mr_valid;
    logic rst_cause;
    logic kick_fall;
    logic kick_edge;

    // Two-stage synchroniser; only pins (the second stage) feeds logic. [R19]
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pins_meta <= sow_pkg::PINS_IDLE;
            pins <= sow_pkg::PINS_IDLE;
        end else if (ce) begin
            pins_meta <= {uv_flags, ov_flags, manual_reset_n, output_freeze_n, watchdog_kick_in};
            pins <= pins_meta;
        end
    end

    // Freezing stops every timer too, so outputs resume exactly where they left off.
    assign adv = ce && pins.output_freeze_n; // [R16] [R17]
    assign any_uv = |pins.uv;
    assign any_ov = |pins.ov;
    assign mr_valid = (mr_cnt == sow_pkg::MR_CYC);
    assign rst_cause = any_uv || mr_valid; // [R04]
    assign kick_fall = kick_d && !pins.watchdog_kick_in;
    assign kick_edge = kick_d != pins.watchdog_kick_in;

    // Manual reset qualifier: must stay low for the full count to count. [R15]
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mr_cnt <= '0;
        end else if (adv) begin
            if (pins.manual_reset_n) begin
                mr_cnt <= '0;
            end else if (!mr_valid) begin
                mr_cnt <= mr_cnt + 1'b1;
            end
        end
    end

    // Overvoltage flag with release timeout. [R01] [R02] [R03]
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ov_cnt <= sow_pkg::OV_CYC;
            overvoltage_flag_n <= sow_pkg::OV_FLAG_RST;
        end else if (adv) begin
            if (any_ov) begin
                ov_cnt <= sow_pkg::OV_CYC;
            end else if (ov_cnt != '0) begin
                ov_cnt <= ov_cnt - 1'b1;
            end
            overvoltage_flag_n <= !(any_ov || ov_cnt != '0);
        end
    end

    // Reset output; any cause reloads the full timeout, including a watchdog loopback. [R01] [R02] [R05] [R14]
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rst_cnt <= RST_CYC;
            reset_out_n <= sow_pkg::RESET_OUT_RST;
        end else if (adv) begin
            if (rst_cause) begin
                rst_cnt <= RST_CYC;
            end else if (rst_cnt != '0) begin
                rst_cnt <= rst_cnt - 1'b1;
            end
            reset_out_n <= !(rst_cause || rst_cnt != '0);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            kick_d <= 1'b0;
        end else if (adv) begin
            kick_d <= pins.watchdog_kick_in;
        end
    end

    // Watchdog sequencer. [R06]
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wd_state <= sow_pkg::WD_CLEAR;
            wd_cnt <= '0;
            pulse_cnt <= '0;
            watchdog_out_n <= sow_pkg::WDO_RST;
        end else if (adv) begin
            unique case (wd_state)
                sow_pkg::WD_CLEAR: begin
                    watchdog_out_n <= 1'b1;
                    if (reset_out_n) begin
                        wd_state <= sow_pkg::WD_INITIAL; // [R07]
                        wd_cnt <= WD_INIT_CYC - 1'b1;
                    end
                end
                sow_pkg::WD_INITIAL, sow_pkg::WD_NORMAL: begin
                    if (!reset_out_n) begin
                        wd_state <= sow_pkg::WD_CLEAR; // [R13]
                        wd_cnt <= '0;
                    end else if (kick_fall) begin
                        wd_state <= sow_pkg::WD_NORMAL; // [R08]
                        wd_cnt <= WD_NORM_CYC - 1'b1;
                    end else if (wd_cnt == '0) begin
                        wd_state <= sow_pkg::WD_FAULT; // [R09]
                        watchdog_out_n <= 1'b0;
                        pulse_cnt <= '0;
                    end else begin
                        wd_cnt <= wd_cnt - 1'b1;
                    end
                end
                sow_pkg::WD_FAULT: begin
                    if (pulse_cnt != sow_pkg::PULSE_CYC) begin
                        pulse_cnt <= pulse_cnt + 1'b1;
                    end
                    // The low pulse lasts at least the minimum so a looped-back reset is certain. [R12]
                    if (!reset_out_n && pulse_cnt == sow_pkg::PULSE_CYC) begin
                        wd_state <= sow_pkg::WD_CLEAR; // [R13]
                        wd_cnt <= '0;
                        watchdog_out_n <= 1'b1;
                    end else if (kick_edge) begin
                        wd_state <= sow_pkg::WD_INITIAL; // [R10] [R11]
                        wd_cnt <= WD_INIT_CYC - 1'b1;
                        watchdog_out_n <= 1'b1;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_POWERUP_ASSERTED: assert property ($fell(rst) |-> !reset_out_n && !overvoltage_flag_n) // [R02]
        else $error("Outputs not asserted after reset release.");
    AST_OV_ASSERT: assert property (adv && any_ov |=> !overvoltage_flag_n && ov_cnt == sow_pkg::OV_CYC) // [R03]
        else $error("Overvoltage flag not asserted with reloaded hold.");
    AST_OV_RELEASE: assert property ($rose(overvoltage_flag_n) |-> $past(ov_cnt) == '0 && !$past(any_ov)) // [R03]
        else $error("Overvoltage flag released early.");
    AST_RST_UV: assert property (adv && any_uv |=> !reset_out_n && rst_cnt == RST_CYC) // [R04]
        else $error("Reset not asserted on undervoltage.");
    AST_RST_HOLD: assert property ($rose(reset_out_n) |-> $past(rst_cnt) == '0 && !$past(rst_cause)) // [R05]
        else $error("Reset released before timeout.");
    AST_MR_SHORT: assert property (adv && reset_out_n && !any_uv && mr_cnt < sow_pkg::MR_CYC - 1'b1
                                   |=> reset_out_n) // [R15]
        else $error("Short manual reset pulse asserted reset.");
    AST_FREEZE: assert property (!ce || !pins.output_freeze_n
                                 |=> $stable(reset_out_n) && $stable(overvoltage_flag_n) && $stable(watchdog_out_n)) // [R16]
        else $error("Output changed while frozen.");
    AST_FREEZE_MR: assert property (!pins.output_freeze_n && reset_out_n |=> reset_out_n) // [R17]
        else $error("Manual reset acted during freeze.");
    AST_WD_CLEARED: assert property (!reset_out_n && wd_state != sow_pkg::WD_FAULT |=> watchdog_out_n) // [R13]
        else $error("Watchdog output low while reset asserted.");
    AST_WD_TIMEOUT: assert property (adv && reset_out_n && wd_state == sow_pkg::WD_NORMAL && wd_cnt == '0 && !kick_fall
                                     |=> !watchdog_out_n) // [R09]
        else $error("Watchdog timeout missed.");
    AST_WD_RELEASE: assert property (adv && wd_state == sow_pkg::WD_FAULT && kick_edge && reset_out_n
                                     |=> watchdog_out_n && wd_state == sow_pkg::WD_INITIAL
                                         && wd_cnt == WD_INIT_CYC - 1'b1) // [R10] [R11]
        else $error("Watchdog not released into initial period.");

    COV_OV_CYCLE: cover property ($rose(overvoltage_flag_n));
    COV_MR_RESET: cover property (adv && mr_valid ##1 !reset_out_n);
    COV_WD_FAULT: cover property ($fell(watchdog_out_n));
    COV_WD_NORMAL: cover property (wd_state == sow_pkg::WD_NORMAL && kick_fall);
endmodule // sow_supervisor

//--- verif/sow_cpu_model.sv
`timescale 1ns/1ps
module sow_cpu_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Bench control and supervisor status.
    input wire logic kick_en,
    input wire logic [7:0] half_per,
    input wire logic reset_out_n,
    // Kick towards the supervisor.
    output logic watchdog_kick_in
);
    logic [7:0] cnt;
    // A processor held in reset runs no code, so it never kicks then.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt <= 8'h00;
            watchdog_kick_in <= 1'b0;
        end else if (kick_en && reset_out_n) begin
            if (cnt >= half_per - 8'h01) begin
                cnt <= 8'h00;
                watchdog_kick_in <= ~watchdog_kick_in;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end else begin
            cnt <= 8'h00;
        end
    end
endmodule // sow_cpu_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module tb_top;
    localparam int RST_N = 50;
    localparam int INIT_N = 300;
    localparam int NORM_N = 100;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [5:0] uv_flags = 6'h00;
    logic [5:0] ov_flags = 6'h00;
    logic manual_reset_n = 1'b1;
    logic mr_drv = 1'b1;
    logic output_freeze_n = 1'b1;
    logic kick_en = 1'b0;
    logic loop = 1'b0;
    logic [7:0] half_per = 8'h14;
    logic watchdog_kick_in, reset_out_n, overvoltage_flag_n, watchdog_out_n;
    logic [31:0] seed = 32'h0000c63f;
    int n_mismatch = 0;
    int checked = 0;
    int n;
    always #12.5 sys_clk = ~sys_clk;
    // One driver for the manual reset pin; the loopback takes it over when enabled.
    always @(posedge sys_clk) manual_reset_n <= loop ? watchdog_out_n : mr_drv;
    sow_supervisor #(.RST_CYC(24'h32), .WD_INIT_CYC(32'h12c), .WD_NORM_CYC(32'h64)) dut (.sys_clk(sys_clk),
        .rst(rst), .ce(ce), .uv_flags(uv_flags), .ov_flags(ov_flags), .manual_reset_n(manual_reset_n),
        .output_freeze_n(output_freeze_n), .watchdog_kick_in(watchdog_kick_in), .reset_out_n(reset_out_n),
        .overvoltage_flag_n(overvoltage_flag_n), .watchdog_out_n(watchdog_out_n));
    sow_cpu_model cpu (.sys_clk(sys_clk), .rst(rst), .kick_en(kick_en), .half_per(half_per),
        .reset_out_n(reset_out_n), .watchdog_kick_in(watchdog_kick_in));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Two synchroniser flops and the output flop add three cycles to every hold.
    function automatic int rel_of(int hold);
        return hold + 3;
    endfunction
    function automatic logic pick(int s);
        return (s == 0) ? reset_out_n : ((s == 1) ? overvoltage_flag_n : watchdog_out_n);
    endfunction
    task automatic cyc(int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_lvl(int s, logic v, int mx);
        n = 0;
        while (pick(s) !== v && n < mx) begin
            cyc(1);
            n++;
        end
        `CHK("level", v, pick(s))
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        kick_en <= 1'b1;
        half_per <= 8'(xs() % 30 + 10);
        cyc(1);
        `CHK("rst_n", 1'b0, reset_out_n)
        `CHK("ov_n", 1'b0, overvoltage_flag_n)
        `CHK("wdo_n", 1'b1, watchdog_out_n)
        cyc(rel_of(RST_N) - 18);
        `CHK("rst_n", 1'b0, reset_out_n)
        cyc(20);
        `CHK("rst_n", 1'b1, reset_out_n)
        cyc(900);
        `CHK("ov_n", 1'b0, overvoltage_flag_n)
        cyc(100);
        `CHK("ov_n", 1'b1, overvoltage_flag_n)
        `CHK("wdo_n", 1'b1, watchdog_out_n)
        repeat (2) begin
            @(posedge sys_clk) ov_flags <= 6'h01 << (xs() % 6);
            cyc(4);
            `CHK("ov_n", 1'b0, overvoltage_flag_n)
            @(posedge sys_clk) ov_flags <= 6'h00;
            cyc(rel_of(1000) - 13);
            `CHK("ov_n", 1'b0, overvoltage_flag_n)
            cyc(20);
            `CHK("ov_n", 1'b1, overvoltage_flag_n)
        end
        for (int k = 0; k < 6; k++) begin
            @(posedge sys_clk) uv_flags <= 6'h01 << k;
            cyc(xs() % 8 + 4);
            `CHK("rst_n", 1'b0, reset_out_n)
            @(posedge sys_clk) uv_flags <= 6'h00;
            cyc(30);
            @(posedge sys_clk) uv_flags <= 6'h01 << ((k + 1) % 6);
            repeat (2) @(posedge sys_clk);
            uv_flags <= 6'h00;
            cyc(rel_of(RST_N) - 8);
            `CHK("rst_n", 1'b0, reset_out_n)
            cyc(15);
            `CHK("rst_n", 1'b1, reset_out_n)
        end
        @(posedge sys_clk) mr_drv <= 1'b0;
        repeat (xs() % 30 + 5) @(posedge sys_clk);
        mr_drv <= 1'b1;
        cyc(10);
        `CHK("rst_n", 1'b1, reset_out_n)
        @(posedge sys_clk) mr_drv <= 1'b0;
        cyc(60);
        `CHK("rst_n", 1'b0, reset_out_n)
        @(posedge sys_clk) mr_drv <= 1'b1;
        cyc(rel_of(RST_N) - 8);
        `CHK("rst_n", 1'b0, reset_out_n)
        cyc(15);
        `CHK("rst_n", 1'b1, reset_out_n)
        @(posedge sys_clk) output_freeze_n <= 1'b0;
        cyc(4);
        @(posedge sys_clk) uv_flags <= 6'h3f;
        ov_flags <= 6'h3f;
        mr_drv <= 1'b0;
        cyc(60);
        `CHK("rst_n", 1'b1, reset_out_n)
        `CHK("ov_n", 1'b1, overvoltage_flag_n)
        @(posedge sys_clk) uv_flags <= 6'h00;
        ov_flags <= 6'h00;
        mr_drv <= 1'b1;
        cyc(5);
        @(posedge sys_clk) output_freeze_n <= 1'b1;
        // Long enough for a falling kick to move the watchdog into its normal period.
        cyc(100);
        `CHK("rst_n", 1'b1, reset_out_n)
        @(posedge sys_clk) kick_en <= 1'b0;
        wait_lvl(2, 1'b0, 400);
        `CHK("wd_norm", 1'b1, n <= rel_of(NORM_N) + 1)
        cyc(50);
        `CHK("wdo_n", 1'b0, watchdog_out_n)
        @(posedge sys_clk) kick_en <= 1'b1;
        wait_lvl(2, 1'b1, 60);
        @(posedge sys_clk) kick_en <= 1'b0;
        loop <= 1'b1;
        wait_lvl(2, 1'b0, 400);
        `CHK("wd_init", 1'b1, n >= INIT_N - 10)
        wait_lvl(2, 1'b1, 400);
        `CHK("wdo_pulse", 1'b1, n >= 200 && n <= 260)
        cyc(10);
        `CHK("rst_n", 1'b0, reset_out_n)
        `CHK("wdo_n", 1'b1, watchdog_out_n)
        wait_lvl(0, 1'b1, 200);
        `CHK("rst_hold", 1'b1, n + 10 >= RST_N)
        @(posedge sys_clk) ce <= 1'b0;
        ov_flags <= 6'h3f;
        cyc(20);
        `CHK("ov_n", 1'b1, overvoltage_flag_n)
        @(posedge sys_clk) ce <= 1'b1;
        cyc(6);
        `CHK("ov_n", 1'b0, overvoltage_flag_n)
        tally_and_finish();
    end
endmodule // tb_top
